// >>> rtl/hdlc_datapath_consts.vh
/*
 * Register map, field positions, reset values and protocol constants of the
 * multichannel HDLC datapath. Definitions only; included by hdlc_datapath.v.
 */
`ifndef HDLC_DATAPATH_CONSTS_VH
`define HDLC_DATAPATH_CONSTS_VH

// Register byte offsets, one aligned word each
`define OFS_MODE         8'h00
`define OFS_CHSEL        8'h04
`define OFS_CHCFG        8'h08
`define OFS_CHTX         8'h0C
`define OFS_CHCMD        8'h10
`define OFS_SMALLSZ      8'h14
`define OFS_DROPLIM      8'h18
`define OFS_DROPCNT      8'h1C
`define OFS_MAXLEN       8'h20
`define OFS_FILLTH       8'h24
`define OFS_RXFILL       8'h28
`define OFS_BURSTLIM     8'h2C

// Field positions
`define MODE_SWAP        0
`define CFG_CRC32        0
`define CFG_CRCOFF       1
`define CFG_IDLEONES     2
`define CFG_INVERT       3
`define CFG_SHARED       4
`define CFG_RXTH_LO      8
`define CFG_W            14
`define TX_FWD_LO        0
`define TX_REFILL_LO     10
`define TX_SIZE_LO       20
`define CMD_ABORT        0

// Reset values
`define RST_CHCFG        14'h0_100
`define RST_CHTX         32'h0400_2008
`define RST_SMALLSZ      12'h003
`define RST_DROPLIM      16'h0010
`define RST_MAXLEN       12'h600
`define RST_FILLTH       32'h0C00_0600
`define RST_BURSTLIM     7'h40

// Protocol figures
`define SHORT16          12'h004
`define SHORT32          12'h006
`define CRC16_POLY       16'h8408
`define CRC32_POLY       32'hEDB8_8320
`define CRC_INIT         32'hFFFF_FFFF
`define CRC16_GOOD       16'hF0B8
`define CRC32_GOOD       32'hDEBB_20E3
`define ABORT_ONES       6'h06

`endif

// >>> rtl/hdlc_datapath.v
/*
 * Multichannel HDLC datapath: per-channel bit-serial receive and transmit
 * protocol machines for 256 time-shared channels, receive word packing with
 * endian swap, transfer requests, small-frame dropping, fill monitoring,
 * and transmit forward/refill accounting. AXI4-Lite register slave.
 * Assumes line, DMA and store logic share the single clock; the transmit
 * store presents the head word of lineTxChan combinationally.
 */
// The address map and register access over AXI4-Lite were left to the implementer.
// Functional notes
// (R1) Little endian default; swap when enable set
// (R2) Swap only packet data words
// (R3) Big endian: byte 0 in top lane
// (R4) Bytes in order, bits LSB first
// (R5) Word writes; request at threshold or end
// (R6) Software keeps receive thresholds within buffer
// (R7) Drop small frames, count, signal limit
// (R8) Signal receive fill threshold crossings
// (R9) Software sizes transmit buffers and thresholds
// (R10) Forward only at threshold or whole frame
// (R11) Request refills below threshold, burst capped
// (R12) 256 channels, per-channel state and config
// (R13) Flag delimits; shared flag/zero rules
// (R14) Idle fill flags or all ones
// (R15) Receiver drops stuffed zero bits
// (R16) Closing flag runs all frame checks
// (R17) Short frame sizes; seven ones abort
// (R18) Transmitter stuffs zero after five ones
// (R19) Frame end appends CRC then flag
// (R20) Underrun or command sends abort
// (R21) Optional per-channel line inversion
// (R22) CRC16/CRC32, CRC optional per channel
`timescale 1ns/1ps
`include "hdlc_datapath_consts.vh"

module hdlc_datapath (
	input  wire        clock,
	input  wire        reset,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        lineRxValid,
	input  wire [7:0]  lineRxChan,
	input  wire        lineRxBit,
	input  wire        lineTxReq,
	input  wire [7:0]  lineTxChan,
	output reg         lineTxValid,
	output reg         lineTxBit,
	output reg         rxWordValid,
	output reg  [7:0]  rxWordChan,
	output reg  [31:0] rxWord,
	output reg  [2:0]  rxWordBytes,
	output reg         rxWordLast,
	output reg  [5:0]  rxWordStatus,
	output reg         rxXferReq,
	output reg  [7:0]  rxXferChan,
	input  wire        rxWordDrained,
	output reg         dropLimitEvent,
	output reg         fillEvent,
	input  wire [31:0] txHeadWord,
	input  wire [2:0]  txHeadBytes,
	input  wire        txHeadEnd,
	output reg         txWordTake,
	input  wire        txFillValid,
	input  wire [7:0]  txFillChan,
	input  wire [8:0]  txFillBytes,
	input  wire        txFillEnd,
	output reg         txRefillReq,
	output reg  [7:0]  txRefillChan,
	output reg  [6:0]  txRefillDwords,
	output reg         txUnderrun,
	output reg  [7:0]  txUnderrunChan
);

	localparam [5:0] T_IDLE  = 6'b000001;
	localparam [5:0] T_OPEN  = 6'b000010;
	localparam [5:0] T_DATA  = 6'b000100;
	localparam [5:0] T_CRC   = 6'b001000;
	localparam [5:0] T_CLOSE = 6'b010000;
	localparam [5:0] T_ABORT = 6'b100000;

	function [31:0] swapBytes;
		input [31:0] w;
		input        en;
		begin
			swapBytes = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
		end
	endfunction

	function [31:0] crcStep;
		input [31:0] c;
		input        b;
		input        is32;
		reg          fb;
		begin
			fb = c[0] ^ b;
			if (is32)
				crcStep = (c >> 1) ^ (fb ? `CRC32_POLY : 32'h0000_0000);
			else
				crcStep = {16'h0000, (c[15:0] >> 1) ^ (fb ? `CRC16_POLY : 16'h0000)};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer      k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[8*k +: 8] = nw[8*k +: 8];
		end
	endfunction

	function flagBit;
		input [2:0] idx;
		begin
			flagBit = (idx != 3'd0) && (idx != 3'd7);
		end
	endfunction

	// Global registers
	reg                swap_r;
	reg  [7:0]         chSel_r;
	reg  [11:0]        smallSize_r;
	reg  [15:0]        dropLimit_r;
	reg  [15:0]        dropCnt_r;
	reg  [11:0]        maxLen_r;
	reg  [31:0]        fillTh_r;
	reg  [11:0]        rxOcc_r;
	reg  [6:0]         burstLim_r;

	// Per-channel configuration and state
	reg  [`CFG_W-1:0]  chCfg   [0:255];
	reg  [31:0]        chTx    [0:255];
	reg  [2:0]         rOnes   [0:255];
	reg  [6:0]         rDly    [0:255];
	reg  [2:0]         rDlyN   [0:255];
	reg                rInFr   [0:255];
	reg  [2:0]         rBitN   [0:255];
	reg  [7:0]         rByte   [0:255];
	reg  [11:0]        rOct    [0:255];
	reg  [31:0]        rCrc    [0:255];
	reg  [31:0]        rWordA  [0:255];
	reg  [1:0]         rLane   [0:255];
	reg  [5:0]         rWcnt   [0:255];
	reg  [5:0]         tState  [0:255];
	reg  [2:0]         tIdx    [0:255];
	reg  [2:0]         tOnes   [0:255];
	reg  [31:0]        tCrc    [0:255];
	reg  [5:0]         tCnt    [0:255];
	reg  [1:0]         tLane   [0:255];
	reg  [15:0]        tLevel  [0:255];
	reg  [7:0]         tFrames [0:255];
	reg                tPend   [0:255];
	reg                tAbort  [0:255];
	integer            i;

	// One view for reads and for strobe merging, so both stay in step
	function [31:0] regView;
		input [7:0] a;
		begin
			case (a)
				`OFS_MODE:     regView = {31'h0, swap_r};
				`OFS_CHSEL:    regView = {24'h0, chSel_r};
				`OFS_CHCFG:    regView = {18'h0, chCfg[chSel_r]};
				`OFS_CHTX:     regView = chTx[chSel_r];
				`OFS_CHCMD:    regView = {tLevel[chSel_r], tFrames[chSel_r], 1'b0, tAbort[chSel_r], tState[chSel_r]};
				`OFS_SMALLSZ:  regView = {20'h0, smallSize_r};
				`OFS_DROPLIM:  regView = {16'h0, dropLimit_r};
				`OFS_DROPCNT:  regView = {16'h0, dropCnt_r}; // R7
				`OFS_MAXLEN:   regView = {20'h0, maxLen_r};
				`OFS_FILLTH:   regView = fillTh_r;
				`OFS_RXFILL:   regView = {20'h0, rxOcc_r};
				`OFS_BURSTLIM: regView = {25'h0, burstLim_r};
				default:       regView = 32'h0000_0000;
			endcase
		end
	endfunction

	wire [31:0] wrNew  = merge(regView(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
	wire        rdMiss = (s_axi_araddr > `OFS_BURSTLIM) || (s_axi_araddr[1:0] != 2'b00);

	// AXI write and read handshakes
	wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire rdGo = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wrGo;
	assign s_axi_wready  = wrGo;
	assign s_axi_arready = rdGo;
	wire wrCmd     = wrGo && (s_axi_awaddr == `OFS_CHCMD) && s_axi_wstrb[0] && s_axi_wdata[`CMD_ABORT];
	wire wrDropClr = wrGo && (s_axi_awaddr == `OFS_DROPCNT);

	// Receive bit processing for the channel on the line this cycle
	wire [7:0]         rc   = lineRxChan;
	wire [`CFG_W-1:0]  rCfg = chCfg[rc];
	wire               rIs32 = rCfg[`CFG_CRC32];
	wire               rb   = lineRxBit ^ rCfg[`CFG_INVERT]; // R21
	reg  [2:0]         o_n, dn_n, bc_n;
	reg  [6:0]         d_n;
	reg                fr_n, dataBit, haveBit, closeNow, abortNow, push, emit, emLast, xfer;
	reg  [7:0]         by_n;
	reg  [11:0]        oc_n;
	reg  [31:0]        cr_n, wd_n;
	reg  [1:0]         ln_n;
	reg  [5:0]         wc_n, status;
	reg  [2:0]         emBytes;
	reg                smallDrop;

	always @* begin
		o_n = rOnes[rc]; d_n = rDly[rc]; dn_n = rDlyN[rc]; fr_n = rInFr[rc];
		bc_n = rBitN[rc]; by_n = rByte[rc]; oc_n = rOct[rc]; cr_n = rCrc[rc];
		wd_n = rWordA[rc]; ln_n = rLane[rc]; wc_n = rWcnt[rc];
		dataBit = 1'b0; haveBit = 1'b0; closeNow = 1'b0; abortNow = 1'b0; push = 1'b0;
		emit = 1'b0; emLast = 1'b0; emBytes = 3'd4; status = 6'h00; xfer = 1'b0; smallDrop = 1'b0;
		if (rb) begin
			push = 1'b1;
			if (o_n == 3'd6) begin
				abortNow = fr_n; // R17
				fr_n = 1'b0;
			end
			if (o_n != 3'd7)
				o_n = o_n + 3'd1;
		end else begin
			if (o_n == 3'd6)
				closeNow = 1'b1; // R13
			else if (o_n != 3'd5)
				push = 1'b1; // R15
			o_n = 3'd0;
		end
		// Seven-bit delay hides the flag's leading bits from the data path
		if (push) begin
			if (dn_n == 3'd7) begin
				haveBit = fr_n;
				dataBit = d_n[0];
				d_n = {rb, d_n[6:1]};
			end else begin
				d_n[dn_n] = rb;
				dn_n = dn_n + 3'd1;
			end
		end
		if (haveBit) begin
			cr_n = crcStep(cr_n, dataBit, rIs32);
			by_n = {dataBit, by_n[7:1]}; // R4
			bc_n = bc_n + 3'd1;
			if (bc_n == 3'd0) begin
				oc_n = oc_n + 12'd1;
				wd_n[{ln_n, 3'b000} +: 8] = by_n; // R4
				ln_n = ln_n + 2'd1;
				if (ln_n == 2'd0) begin
					emit = 1'b1; // R5
					wc_n = wc_n + 6'd1;
					if (wc_n >= rCfg[`CFG_RXTH_LO +: 6]) begin
						xfer = 1'b1; // R5
						wc_n = 6'd0;
					end
				end
			end
		end
		if (abortNow) begin
			emit = 1'b1; emLast = 1'b1; emBytes = {1'b0, ln_n}; status[5] = 1'b1;
			xfer = 1'b1; wc_n = 6'd0;
		end
		if (closeNow && fr_n && (oc_n != 12'd0 || bc_n != 3'd0)) begin
			// R16
			if (!rCfg[`CFG_CRCOFF])
				status[0] = rIs32 ? (cr_n != `CRC32_GOOD) : (cr_n[15:0] != `CRC16_GOOD); // R22
			status[1] = (bc_n != 3'd0);
			status[2] = (oc_n > maxLen_r);
			status[3] = (oc_n < (rIs32 ? `SHORT32 : `SHORT16)); // R17
			smallDrop = (oc_n <= smallSize_r); // R7
			status[4] = smallDrop;
			emit = 1'b1; emLast = 1'b1; emBytes = {1'b0, ln_n};
			xfer = 1'b1; wc_n = 6'd0; // R5
		end
		if (closeNow) begin
			fr_n = 1'b1; dn_n = 3'd0; bc_n = 3'd0; oc_n = 12'd0; ln_n = 2'd0;
			cr_n = `CRC_INIT; wd_n = 32'h0000_0000;
		end
		if (emit && !closeNow && !emLast)
			wd_n = 32'h0000_0000;
	end

	// Transmit bit processing for the requested channel
	wire [7:0]         tc    = lineTxChan;
	wire [`CFG_W-1:0]  tCfg  = chCfg[tc];
	wire [31:0]        tParm = chTx[tc];
	wire [15:0]        lvl   = tLevel[tc];
	wire               tRel  = (lvl >= {4'h0, tParm[`TX_FWD_LO +: 10], 2'b00}) || (tFrames[tc] != 8'h00); // R10
	wire [31:0]        headW = swapBytes(txHeadWord, swap_r); // R1 R3
	reg  [5:0]         st_n, cnt_n;
	reg  [2:0]         ix_n, to_n;
	reg  [31:0]        tc_n;
	reg  [1:0]         tl_n;
	reg                outBit, take, consume, under, endByte, abortClr;

	always @* begin
		st_n = tState[tc]; ix_n = tIdx[tc]; to_n = tOnes[tc]; tc_n = tCrc[tc];
		cnt_n = tCnt[tc]; tl_n = tLane[tc];
		outBit = 1'b1; take = 1'b0; consume = 1'b0; under = 1'b0; endByte = 1'b0; abortClr = 1'b0;
		if ((st_n == T_DATA || st_n == T_CRC) && tAbort[tc]) begin
			st_n = T_ABORT; cnt_n = 6'd0; abortClr = 1'b1; // R20
		end
		case (st_n)
			T_IDLE, T_OPEN, T_CLOSE: begin
				abortClr = tAbort[tc];
				outBit = (st_n == T_IDLE && tCfg[`CFG_IDLEONES]) ? 1'b1 : flagBit(ix_n); // R14
				if (ix_n == 3'd7) begin
					if (st_n == T_OPEN)
						st_n = T_DATA;
					else if (!tRel || tAbort[tc])
						st_n = T_IDLE;
					else if (st_n == T_IDLE)
						st_n = tCfg[`CFG_IDLEONES] ? T_OPEN : T_DATA;
					else
						st_n = tCfg[`CFG_SHARED] ? T_DATA : T_OPEN; // R13
					to_n = 3'd0;
					tc_n = `CRC_INIT;
				end
				ix_n = ix_n + 3'd1;
			end
			T_DATA: begin
				if (to_n == 3'd5) begin
					outBit = 1'b0; // R18
					to_n = 3'd0;
				end else if (ix_n == 3'd0 && lvl == 16'h0000) begin
					under = 1'b1; st_n = T_ABORT; cnt_n = 6'd1; // R20
				end else begin
					outBit = headW[{tl_n, ix_n}]; // R4
					tc_n = crcStep(tc_n, outBit, tCfg[`CFG_CRC32]);
					to_n = outBit ? to_n + 3'd1 : 3'd0;
					if (ix_n == 3'd7) begin
						consume = 1'b1;
						tl_n = tl_n + 2'd1;
						if ({1'b0, tl_n} == txHeadBytes[2:0] || tl_n == 2'd0) begin
							take = 1'b1;
							tl_n = 2'd0;
							if (txHeadEnd) begin
								endByte = 1'b1; // R19
								st_n = tCfg[`CFG_CRCOFF] ? T_CLOSE : T_CRC; // R22
								cnt_n = 6'd0;
							end
						end
					end
					ix_n = ix_n + 3'd1;
				end
			end
			T_CRC: begin
				if (to_n == 3'd5) begin
					outBit = 1'b0; // R18
					to_n = 3'd0;
				end else begin
					outBit = ~tc_n[cnt_n[4:0]]; // R19
					to_n = outBit ? to_n + 3'd1 : 3'd0;
					if (cnt_n == (tCfg[`CFG_CRC32] ? 6'd31 : 6'd15)) begin
						st_n = T_CLOSE; ix_n = 3'd0;
					end
					cnt_n = cnt_n + 6'd1;
				end
			end
			T_ABORT: begin
				if (cnt_n >= `ABORT_ONES) begin
					st_n = T_IDLE; ix_n = 3'd0; // R20
				end
				cnt_n = cnt_n + 6'd1;
			end
			default: begin
				st_n = T_IDLE; ix_n = 3'd0;
			end
		endcase
		outBit = outBit ^ tCfg[`CFG_INVERT]; // R21
	end

	always @* begin
		txWordTake = lineTxReq && take;
	end

	wire        fillSame = txFillValid && lineTxReq && (txFillChan == tc);
	wire        rxEmitN  = lineRxValid && emit && !(smallDrop && emLast) && (emBytes != 3'd0 || emLast);
	wire [11:0] occNxt   = rxOcc_r + {11'h000, lineRxValid && emit && emBytes != 3'd0 && !smallDrop}
	                       - {11'h000, rxWordDrained && rxOcc_r != 12'h000};
	wire [11:0] refillRoom = tParm[`TX_SIZE_LO +: 12] - lvl[13:2];

	always @(posedge clock) begin
		if (reset) begin
			swap_r <= 1'b0; chSel_r <= 8'h00; smallSize_r <= `RST_SMALLSZ;
			dropLimit_r <= `RST_DROPLIM; dropCnt_r <= 16'h0000; maxLen_r <= `RST_MAXLEN;
			fillTh_r <= `RST_FILLTH; rxOcc_r <= 12'h000; burstLim_r <= `RST_BURSTLIM;
			s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00; s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= 2'b00;
			lineTxValid <= 1'b0; lineTxBit <= 1'b1; rxWordValid <= 1'b0; rxWordChan <= 8'h00;
			rxWord <= 32'h0000_0000; rxWordBytes <= 3'd0; rxWordLast <= 1'b0; rxWordStatus <= 6'h00;
			rxXferReq <= 1'b0; rxXferChan <= 8'h00; dropLimitEvent <= 1'b0; fillEvent <= 1'b0;
			txRefillReq <= 1'b0; txRefillChan <= 8'h00; txRefillDwords <= 7'h00;
			txUnderrun <= 1'b0; txUnderrunChan <= 8'h00;
			for (i = 0; i < 256; i = i + 1) begin
				chCfg[i] <= `RST_CHCFG; chTx[i] <= `RST_CHTX;
				rOnes[i] <= 3'd0; rDly[i] <= 7'h00; rDlyN[i] <= 3'd0; rInFr[i] <= 1'b0;
				rBitN[i] <= 3'd0; rByte[i] <= 8'h00; rOct[i] <= 12'h000; rCrc[i] <= `CRC_INIT;
				rWordA[i] <= 32'h0000_0000; rLane[i] <= 2'd0; rWcnt[i] <= 6'd0;
				tState[i] <= T_IDLE; tIdx[i] <= 3'd0; tOnes[i] <= 3'd0; tCrc[i] <= `CRC_INIT;
				tCnt[i] <= 6'd0; tLane[i] <= 2'd0; tLevel[i] <= 16'h0000; tFrames[i] <= 8'h00;
				tPend[i] <= 1'b0; tAbort[i] <= 1'b0;
			end
		end else begin
			// Register writes; control registers stay little endian
			if (wrGo) begin // R2
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (s_axi_awaddr)
					`OFS_MODE:     swap_r <= wrNew[`MODE_SWAP]; // R1
					`OFS_CHSEL:    chSel_r <= wrNew[7:0];
					`OFS_CHCFG:    chCfg[chSel_r] <= wrNew[`CFG_W-1:0]; // R12
					`OFS_CHTX:     chTx[chSel_r] <= wrNew;
					`OFS_CHCMD:    ;
					`OFS_SMALLSZ:  smallSize_r <= wrNew[11:0];
					`OFS_DROPLIM:  dropLimit_r <= wrNew[15:0];
					`OFS_DROPCNT:  ;
					`OFS_MAXLEN:   maxLen_r <= wrNew[11:0];
					`OFS_FILLTH:   fillTh_r <= wrNew;
					`OFS_BURSTLIM: burstLim_r <= wrNew[6:0];
					default:       s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rdGo) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= regView(s_axi_araddr);
				s_axi_rresp <= rdMiss ? 2'b10 : 2'b00;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;

			// Receive side
			rxWordValid <= rxEmitN;
			rxXferReq <= lineRxValid && xfer && !smallDrop;
			dropLimitEvent <= 1'b0;
			if (lineRxValid) begin
				rOnes[rc] <= o_n; rDly[rc] <= d_n; rDlyN[rc] <= dn_n; rInFr[rc] <= fr_n;
				rBitN[rc] <= bc_n; rByte[rc] <= by_n; rOct[rc] <= oc_n; rCrc[rc] <= cr_n;
				rWordA[rc] <= wd_n; rLane[rc] <= ln_n; rWcnt[rc] <= wc_n;
				rxWordChan <= rc; rxXferChan <= rc;
				rxWord <= swapBytes(rCfg[0] ? rWordA[rc] : rWordA[rc], swap_r); // R3
				if (emit && !emLast)
					rxWord <= swapBytes({by_n, rWordA[rc][23:0]}, swap_r); // R1
				rxWordBytes <= emBytes; rxWordLast <= emLast; rxWordStatus <= status;
				if (closeNow && smallDrop) begin
					dropLimitEvent <= (dropCnt_r + 16'h0001 == dropLimit_r); // R7
				end
			end
			// A software clear and an increment in the same cycle both apply: the count restarts at one
			if (lineRxValid && closeNow && smallDrop && status[4])
				dropCnt_r <= wrDropClr ? 16'h0001 : dropCnt_r + 16'h0001; // R7
			else if (wrDropClr)
				dropCnt_r <= 16'h0000;
			rxOcc_r <= occNxt;
			fillEvent <= ((rxOcc_r < fillTh_r[11:0]) != (occNxt < fillTh_r[11:0]))
			           || ((rxOcc_r < fillTh_r[27:16]) != (occNxt < fillTh_r[27:16])); // R8

			// Transmit side
			lineTxValid <= lineTxReq;
			txUnderrun <= lineTxReq && under; // R20
			txRefillReq <= 1'b0;
			if (lineTxReq) begin
				lineTxBit <= outBit;
				txUnderrunChan <= tc;
				tState[tc] <= st_n; tIdx[tc] <= ix_n; tOnes[tc] <= to_n; tCrc[tc] <= tc_n;
				tCnt[tc] <= cnt_n; tLane[tc] <= tl_n;
				if (abortClr)
					tAbort[tc] <= 1'b0;
				if (consume && !fillSame)
					tLevel[tc] <= lvl - 16'h0001;
				if (endByte && !(fillSame && txFillEnd))
					tFrames[tc] <= tFrames[tc] - 8'h01;
				if (lvl < {4'h0, tParm[`TX_REFILL_LO +: 10], 2'b00} && !tPend[tc] && !fillSame) begin
					txRefillReq <= 1'b1; // R11
					txRefillChan <= tc;
					txRefillDwords <= (refillRoom > {5'h00, burstLim_r}) ? burstLim_r : refillRoom[6:0]; // R11
					tPend[tc] <= 1'b1;
				end
			end
			if (txFillValid) begin
				tLevel[txFillChan] <= tLevel[txFillChan] + {7'h00, txFillBytes}
				                      - {15'h0000, fillSame && consume};
				if (txFillEnd)
					tFrames[txFillChan] <= tFrames[txFillChan] + 8'h01
					                       - {7'h00, fillSame && endByte};
				tPend[txFillChan] <= 1'b0;
			end
			if (wrCmd)
				tAbort[chSel_r] <= 1'b1; // R20
		end
	end

endmodule // hdlc_datapath

// >>> testbench/hdlc_datapath_props.sv
/* Port checker for hdlc_datapath, bound into every instance.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module hdlc_datapath_props (
	input wire        clock,
	input wire        reset,
	input wire        s_axi_awvalid,
	input wire        s_axi_wvalid,
	input wire        s_axi_bvalid,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        lineRxValid,
	input wire        lineTxReq,
	input wire        lineTxValid,
	input wire        rxWordValid,
	input wire [2:0]  rxWordBytes,
	input wire        rxWordLast,
	input wire [5:0]  rxWordStatus,
	input wire        txRefillReq,
	input wire [6:0]  txRefillDwords,
	input wire        txUnderrun
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence wrTaken;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	AST_BANS: assert property (wrTaken |=> s_axi_bvalid) else $error("no write answer");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_TXBIT: assert property (lineTxReq |=> lineTxValid) else $error("tx bit missing");
	AST_TXIDLE: assert property (!lineTxReq |=> !lineTxValid) else $error("tx bit unasked");
	AST_RXSRC: assert property (rxWordValid |-> $past(lineRxValid)) else $error("word without bit");
	AST_FULL: assert property (rxWordValid && !rxWordLast |-> rxWordBytes == 3'h4) else $error("part word");
	AST_STAT: assert property (rxWordValid && rxWordStatus != 6'h00 |-> rxWordLast) else $error("early status");
	AST_BURST: assert property (txRefillReq |-> txRefillDwords <= 7'h40 && txRefillDwords != 7'h00)
		else $error("burst size");
	AST_UNDER: assert property (txUnderrun |-> $past(lineTxReq)) else $error("underrun unasked");
endmodule // hdlc_datapath_props
bind hdlc_datapath hdlc_datapath_props chk_i (.*);

// >>> testbench/dma_partner.sv
/* DMA partner: channel 0 transmit store filled from a source queue per refill request,
   plus receive drain. Assumes the datapath clock and lineTxChan held at 0. */
`timescale 1ns/1ps
module dma_partner (
	input  wire        clock,
	input  wire [3:0]  lag,
	input  wire        txWordTake,
	input  wire        txRefillReq,
	input  wire        rxWordValid,
	output reg         txFillValid = 0,
	output reg  [8:0]  txFillBytes = 0,
	output reg         txFillEnd = 0,
	output reg         rxWordDrained = 0,
	output wire [31:0] txHeadWord,
	output wire [2:0]  txHeadBytes,
	output wire        txHeadEnd
);
	reg [35:0] src[$];
	reg [35:0] st[$];
	reg [35:0] head = 36'h0_5A5A_5A5A;
	int        due = 0;
	assign {txHeadEnd, txHeadBytes, txHeadWord} = head;
	always @(posedge clock) begin
		rxWordDrained <= rxWordValid;
		txFillValid <= due == 1;
		if (txWordTake && st.size() > 0) void'(st.pop_front());
		if (txRefillReq) due = lag + 1;
		else if (due > 1) due = due - 1;
		else if (due == 1) begin
			due = 0;
			// One queued word per answer: serves less than asked, as a busy bus does
			txFillBytes <= src.size() > 0 ? {6'h00, src[0][34:32]} : 9'h000;
			txFillEnd <= src.size() > 0 && src[0][35];
			if (src.size() > 0) st.push_back(src.pop_front());
		end
		// Empty store toggles so a stale head never looks like data
		head <= st.size() > 0 ? st[0] : {4'h0, ~head[31:0]};
	end
endmodule // dma_partner

// >>> testbench/hdlc_datapath_tb.sv
/* Bench for hdlc_datapath: AXI4-Lite tasks, line loopback on channel 0, direct frames on 1.
   Assumes dma_partner as the transmit store. */
`timescale 1ns/1ps
module hdlc_datapath_tb;
	reg        clock = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg        s_axi_arvalid = 0, s_axi_rready = 0, lineRxValid = 0, lineRxBit = 0, lineTxReq = 0;
	reg        lb = 1, be = 0, last = 0, under = 0, dropEv = 0;
	reg [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, lineRxChan = 0, lineTxChan = 0, txFillChan = 0;
	reg [31:0] s_axi_wdata = 0, rdat;
	reg [3:0]  s_axi_wstrb = 4'hF, lag = 0;
	reg [5:0]  stat;
	reg [6:0]  refDw = 0;
	reg [1:0]  rsp;
	wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lineTxValid;
	wire       lineTxBit, rxWordValid, rxWordLast, rxXferReq, rxWordDrained, dropLimitEvent, fillEvent;
	wire       txHeadEnd, txWordTake, txFillValid, txFillEnd, txRefillReq, txUnderrun;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, rxWord, txHeadWord;
	wire [7:0] rxWordChan, rxXferChan, txRefillChan, txUnderrunChan;
	wire [2:0] rxWordBytes, txHeadBytes;
	wire [5:0] rxWordStatus;
	wire [8:0] txFillBytes;
	wire [6:0] txRefillDwords;
	reg [7:0]  got[$];
	reg [7:0]  fr[6] = '{8'h11, 8'h7E, 8'hFF, 8'h3C, 8'hA5, 8'h5F};
	reg [39:0] rv[10] = '{40'h00_0000_0000, 40'h08_0000_0100, 40'h0C_0400_2008, 40'h14_0000_0003,
		40'h18_0000_0010, 40'h1C_0000_0000, 40'h20_0000_0600, 40'h24_0C00_0600, 40'h28_0000_0000,
		40'h2C_0000_0040};
	int        idl[4] = '{12, 16, 4, 0};
	int        err_total = 0, samples_checked = 0, ones = 0, run = 0, maxRun = 0, rx1 = 0;
	hdlc_datapath uut (.*);
	dma_partner partner (.*);
	always #20 clock = ~clock;
	always @(posedge clock) begin
		lineTxReq <= !reset;
		if (lb) begin
			lineRxValid <= lineTxValid;
			lineRxBit <= lineTxBit;
		end
		if (lineTxValid) begin
			ones = ones + lineTxBit;
			run = lineTxBit ? run + 1 : 0;
			maxRun = run > maxRun ? run : maxRun;
		end
		if (rxWordValid) begin
			for (int k = 0; k < rxWordBytes; k++) got.push_back(rxWord[8 * (be ? 3 - k : k) +: 8]);
			if (rxWordLast) begin
				last = 1;
				stat = rxWordStatus;
			end
		end
		under = under | txUnderrun;
		dropEv = dropEv | dropLimitEvent;
		if (txRefillReq && refDw == 0) refDw = txRefillDwords;
	end
	task close_out;
		if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	// Ready sampled mid-cycle: stable then, and equal to its value at the next edge
	task hs(input int s);
		logic h;
		do begin
			@(negedge clock);
			h = s == 0 ? s_axi_awready : s == 1 ? s_axi_bvalid : s == 2 ? s_axi_arready : s_axi_rvalid;
			rsp = s == 1 ? s_axi_bresp : s_axi_rresp;
			rdat = s_axi_rdata;
			@(posedge clock);
		end while (h !== 1'b1);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		hs(0);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		hs(1);
		s_axi_bready <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		hs(2);
		s_axi_arvalid <= 0;
		hs(3);
		s_axi_rready <= 0;
		chk(rdat, e);
	endtask
	task rxbit(input b);
		@(posedge clock);
		lineRxValid <= 1;
		lineRxBit <= b;
		rx1 = b ? rx1 + 1 : 0;
	endtask
	task rxbyte(input [7:0] v, input st);
		for (int i = 0; i < 8; i++) begin
			rxbit(v[i]);
			if (st && rx1 == 5) rxbit(0);
		end
	endtask
	task rxframe(input int n, input ab);
		last = 0;
		got = {};
		rxbyte(8'h7E, 0);
		for (int i = 0; i < n; i++) rxbyte(fr[i], 1);
		rxbyte(ab ? 8'hFF : 8'h7E, 0);
		rxbyte(8'h7E, 0);
		@(posedge clock);
		lineRxValid <= 0;
		repeat (2) @(posedge clock);
	endtask
	task cmpf(input int n, input [5:0] s);
		chk(last, 1);
		chk(stat, s);
		for (int i = 0; i < n; i++) chk(got[i], fr[i]);
	endtask
	task lbrun(input [31:0] cfg, input full);
		wr(8'h08, cfg);
		last = 0;
		got = {};
		partner.src.push_back({4'h4, fr[3], fr[2], fr[1], fr[0]});
		if (full) partner.src.push_back({4'hA, 16'h0000, fr[5], fr[4]});
		for (int n = 0; n < 2000 && !last; n++) @(posedge clock);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		reset <= 0;
		for (int i = 0; i < 10; i++) rd(rv[i][39:32], rv[i][31:0]);
		rd(8'h30, 0);
		chk(rsp, 2);
		for (int i = 0; i < 4; i++) begin
			wr(8'h08, i * 4);
			repeat (20) @(negedge clock);
			ones = 0;
			repeat (16) @(negedge clock);
			chk(ones, idl[i]);
		end
		maxRun = 0;
		for (int i = 0; i < 3; i++) begin
			lbrun(i == 0 ? 2 : i - 1, 1);
			cmpf(6, 0);
		end
		chk(maxRun > 6, 0);
		wr(8'h0C, 32'h0400_2001);
		lag = 4'h6;
		lbrun(2, 0);
		chk(under, 1);
		chk(stat[5], 1);
		chk(refDw, 7'h40);
		lb = 0;
		@(posedge clock);
		lineRxValid <= 0;
		lineRxChan <= 1;
		wr(8'h04, 1);
		wr(8'h08, 2);
		wr(8'h18, 1);
		rxframe(3, 0);
		chk(last, 0);
		chk(dropEv, 1);
		rd(8'h1C, 1);
		rxframe(4, 0);
		cmpf(4, 0);
		rxframe(5, 1);
		chk(stat[5], 1);
		wr(8'h00, 1);
		be = 1;
		rxframe(6, 0);
		cmpf(6, 0);
		close_out;
	end
	initial begin
		#2000000;
		err_total++;
		close_out;
	end
endmodule // hdlc_datapath_tb
